/* include/dpgp_pkg.sv */
// Shared constants and types for the playback gain path.
package dpgp_pkg;
  // Sample width carried through the whole path.
  localparam int SW = 24;

  // Control word addresses.
  localparam logic [6:0] ADDR_PWR3 = 7'h03;
  localparam logic [6:0] ADDR_CONV = 7'h0A;
  localparam logic [6:0] ADDR_VOL  = 7'h0B;
  localparam logic [6:0] ADDR_LIM1 = 7'h18;
  localparam logic [6:0] ADDR_LIM2 = 7'h19;

  // Field positions inside the nine-bit control words.
  localparam int PWR3_EN_BIT    = 0;
  localparam int CONV_INV_BIT   = 0;
  localparam int CONV_ZERO_RUN_MUTE_CONTROL_BIT = 2;
  localparam int CONV_DEEM_LSB  = 4;
  localparam int CONV_SMUTE_BIT = 6;
  localparam int LIM1_EN_BIT    = 8;
  localparam int LIM_HI_LSB     = 4;

  // Values after reset.
  localparam logic [7:0] VOL_UNITY = 8'hFF;
  localparam logic [7:0] VOL_RST   = VOL_UNITY;
  localparam logic [3:0] ATK_RST   = 4'h2;
  localparam logic [3:0] DCY_RST   = 4'h3;
  localparam logic [2:0] LVL_RST   = 3'h0;
  localparam logic [3:0] LIFT_RST  = 4'h0;
  localparam logic [1:0] DEEM_RST  = 2'h0;

  // Zero samples counted before the output mute.
  localparam logic [10:0] ZERO_RUN = 11'h400;
  // Soft-mute depth in half-dB steps; the last step is silence.
  localparam logic [7:0] SMUTE_FULL = 8'hFF;

  // Limiter attenuation: six integer bits of half-dB, fourteen fraction bits.
  localparam int          LIM_FRAC = 14;
  localparam logic [19:0] LATT_CAP = 20'hC0000;
  localparam logic [3:0]  LIFT_MAX = 4'hC;
  localparam logic [3:0]  RATE_MAX = 4'hB;
  localparam logic [2:0]  LVL_MAX  = 3'h5;

  // Shortest attack and decay time per 6 dB at the reference rate.
  localparam longint ATK_BASE_NS = 94000;
  localparam longint DCY_BASE_NS = 750000;
  localparam longint REF_FS_HZ   = 44100;
  localparam longint STEPS_6DB   = 12;
  localparam longint NS_PER_S    = 1000000000;
  // Per-sample increment of the attenuation accumulator for code zero.
  localparam logic [19:0] ATK_INC = 20'(STEPS_6DB * (64'h1 << LIM_FRAC) * NS_PER_S
                                        / (ATK_BASE_NS * REF_FS_HZ));
  localparam logic [19:0] DCY_INC = 20'(STEPS_6DB * (64'h1 << LIM_FRAC) * NS_PER_S
                                        / (DCY_BASE_NS * REF_FS_HZ));

  // Gain per half-dB step within one 6 dB octave, 16'h8000 is unity.
  localparam logic [15:0] MANT [12] = '{16'h8000, 16'h78D1, 16'h7209, 16'h6BA2,
                                        16'h6598, 16'h5FE4, 16'h5A82, 16'h556E,
                                        16'h50A3, 16'h4C1C, 16'h47D6, 16'h43CE};
  // Index bias lets up to 12 dB of lift use the same table.
  localparam logic signed [11:0] GAIN_BIAS  = 12'sh018;
  localparam logic [7:0]         GAIN_SHIFT = 8'h0D;
  localparam logic [7:0]         GAIN_K_MAX = 8'h1B;

  // Limiter thresholds from -0.5 dB down to -6.5 dB full scale in 1 dB steps.
  localparam logic [23:0] THR [7] = '{24'h78D6F5, 24'h6BB2BA, 24'h5FFC85, 24'h558C4A,
                                      24'h4C3EA7, 24'h43F406, 24'h3C9030};

  // De-emphasis pole per sample rate, Q15.
  localparam logic [15:0] DEEM_C32 = 16'h447F;
  localparam logic [15:0] DEEM_C44 = 16'h5155;
  localparam logic [15:0] DEEM_C48 = 16'h5461;

  // Sample processing sequence.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_VOL  = 3'h1,
    ST_DEEM = 3'h2,
    ST_LIM  = 3'h3,
    ST_OUT1 = 3'h4,
    ST_OUT2 = 3'h5
  } dpgp_state_t;
endpackage

/* core/dpgp_fifo.sv */
// Small sample FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module dpgp_fifo #(
  parameter int W = 24,
  parameter int D = 4
) (
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  // Refuse depths that the pointer arithmetic cannot serve.
  if (D < 2 || W < 1) begin : g_chk
    $error("dpgp_fifo needs D of two or more");
  end

  logic [W-1:0]  mem_ff [D];     // Storage words.
  logic [AW-1:0] wr_ff;          // Write index.
  logic [AW-1:0] rd_ff;          // Read index.
  logic [AW:0]   cnt_ff;         // Words held.
  logic [AW-1:0] nxt_wr;
  logic [AW-1:0] nxt_rd;
  logic [AW:0]   nxt_cnt;
  logic          push;
  logic          pop;

  // Full and empty come straight from the count, so neither side is misled.
  assign in_ready_out  = cnt_ff != (AW+1)'(D);
  assign out_valid_out = cnt_ff != '0;
  assign out_data_out  = mem_ff[rd_ff];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // Pointer and count updates; indices wrap at the depth, not at a power of two.
  always_comb
  begin
    nxt_wr  = wr_ff;
    nxt_rd  = rd_ff;
    nxt_cnt = cnt_ff;
    if (push)
    begin
      nxt_wr = (wr_ff == AW'(D - 1)) ? '0 : wr_ff + 1'b1;
    end
    if (pop)
    begin
      nxt_rd = (rd_ff == AW'(D - 1)) ? '0 : rd_ff + 1'b1;
    end
    if (push && !pop)
    begin
      nxt_cnt = cnt_ff + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  // Registers; the storage itself needs no reset.
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
    if (push)
    begin
      mem_ff[wr_ff] <= in_data_in;
    end
  end
endmodule
`default_nettype wire

/* core/dpgp_gain_path.sv */
// Playback gain path: volume, soft mute, de-emphasis, limiter, polarity, interpolation.
`timescale 1ns/1ps
`default_nettype none
module dpgp_gain_path #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        ctrl_wr_in,
  input  wire logic [6:0]  ctrl_addr_in,
  input  wire logic [8:0]  ctrl_data_in,
  input  wire logic        smp_valid_in,
  output logic             smp_ready_out,
  input  wire logic [23:0] playback_serial_in,
  output logic             out_valid_out,
  input  wire logic        out_ready_in,
  output logic [23:0]      out_data_out,
  output logic             zero_mute_out,
  output logic             lim_active_out,
  output logic             path_en_out
);
  // A single buffered word would starve the path while a sample is in flight.
  if (FIFO_DEPTH < 2) begin : g_chk
    $error("dpgp_gain_path needs FIFO_DEPTH of two or more");
  end

  // Control state written over the control word port.
  logic       converter_path_enable_ff, nxt_en;
  logic       soft_mute_request_ff, nxt_smreq;
  logic       output_phase_invert_ff, nxt_inv;
  logic       zero_run_mute_control_ff, nxt_zero_run_mute_control;   // High disables zero-run mute.
  logic [1:0] deem_sel_ff, nxt_deem;                 // 0 off, 1 32k, 2 44.1k, 3 48k.
  logic [7:0] playback_volume_code_ff, nxt_vol;
  logic [3:0] limiter_attack_rate_ff, nxt_atk;
  logic [3:0] limiter_decay_rate_ff, nxt_dcy;
  logic       limiter_enable_ff, nxt_limiter_enable;
  logic [2:0] limiter_level_ff, nxt_lvl;
  logic [3:0] limiter_gain_lift_ff, nxt_lift;

  // Datapath state; samples are signed, state, counts and attenuations unsigned.
  dpgp_pkg::dpgp_state_t state_ff, nxt_state;
  logic signed [23:0] raw_ff, nxt_raw;     // Sample as received.
  logic signed [23:0] g1_ff, nxt_g1;       // After volume and soft mute.
  logic signed [23:0] dm_ff, nxt_dm;       // After de-emphasis; also filter memory.
  logic signed [23:0] pol_ff, nxt_pol;     // After limiter and polarity.
  logic signed [23:0] prev_ff, nxt_prev;   // Previous output, for interpolation.
  logic signed [23:0] out_ff, nxt_out;     // Word presented to the modulator.
  logic [10:0]        zcnt_ff, nxt_zcnt;   // Consecutive zero samples, saturating.
  logic [7:0]         smatt_ff, nxt_smatt; // Soft-mute attenuation, half-dB.
  logic [19:0]        latt_ff, nxt_latt;   // Limiter attenuation with fraction.

  // FIFO drain side.
  logic               f_valid;
  logic               f_ready;
  logic [23:0]        f_data;

  // Combinational helpers.
  logic signed [11:0] att_v, att_l;
  logic signed [23:0] lo, pn;
  logic [23:0]        mag, thr_up, thr_lo;
  logic [2:0]         lvl_i;
  logic [3:0]         lift_e, atk_e, dcy_e;
  logic [19:0]        ainc, dinc;
  logic [20:0]        lsum;
  logic [15:0]        coef;
  logic signed [24:0] ddiff, isum;
  logic signed [47:0] dprod;

  // Saturate a wide value into one sample.
  function automatic logic signed [23:0] sat24(input logic signed [47:0] v);
    if (v > 48'sh7FFFFF) return 24'sh7FFFFF;
    if (v < -48'sh800000) return 24'sh800000;
    return v[23:0];
  endfunction

  // Apply a gain given as half-dB attenuation; negative values lift.
  function automatic logic signed [23:0] gain(input logic signed [23:0] x,
                                              input logic signed [11:0] att);
    logic signed [11:0] n;
    logic [7:0]         k;
    logic [3:0]         m;
    logic signed [47:0] p;
    n = att + dpgp_pkg::GAIN_BIAS;
    if (n < 12'sh000) n = 12'sh000;
    k = 8'(n / 12'sh00C);
    m = 4'(n % 12'sh00C);
    p = 48'(x) * $signed({32'h0, dpgp_pkg::MANT[m]});
    if (k > dpgp_pkg::GAIN_K_MAX) return 24'sh000000;
    return sat24(p >>> (dpgp_pkg::GAIN_SHIFT + k));
  endfunction

  // Input buffer; its ready stalls the serial interface only once all FIFO_DEPTH words are held.
  dpgp_fifo #(.W(dpgp_pkg::SW), .D(FIFO_DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (smp_valid_in),
    .in_ready_out  (smp_ready_out),
    .in_data_in    (playback_serial_in),
    .out_valid_out (f_valid),
    .out_ready_in  (f_ready),
    .out_data_out  (f_data)
  );

  // Control word decode; unknown addresses are ignored.
  always_comb
  begin
    nxt_en    = converter_path_enable_ff;
    nxt_smreq = soft_mute_request_ff;
    nxt_inv   = output_phase_invert_ff;
    nxt_zero_run_mute_control = zero_run_mute_control_ff;
    nxt_deem  = deem_sel_ff;
    nxt_vol   = playback_volume_code_ff;
    nxt_atk   = limiter_attack_rate_ff;
    nxt_dcy   = limiter_decay_rate_ff;
    nxt_limiter_enable = limiter_enable_ff;
    nxt_lvl   = limiter_level_ff;
    nxt_lift  = limiter_gain_lift_ff;
    if (ctrl_wr_in)
    begin
      case (ctrl_addr_in)
        dpgp_pkg::ADDR_PWR3: nxt_en = ctrl_data_in[dpgp_pkg::PWR3_EN_BIT];
        dpgp_pkg::ADDR_CONV:
        begin
          nxt_smreq = ctrl_data_in[dpgp_pkg::CONV_SMUTE_BIT];
          nxt_inv   = ctrl_data_in[dpgp_pkg::CONV_INV_BIT];
          nxt_zero_run_mute_control = ctrl_data_in[dpgp_pkg::CONV_ZERO_RUN_MUTE_CONTROL_BIT];
          nxt_deem  = ctrl_data_in[dpgp_pkg::CONV_DEEM_LSB +: 2];
        end
        dpgp_pkg::ADDR_VOL: nxt_vol = ctrl_data_in[7:0];
        dpgp_pkg::ADDR_LIM1:
        begin
          nxt_limiter_enable = ctrl_data_in[dpgp_pkg::LIM1_EN_BIT];
          nxt_atk   = ctrl_data_in[3:0];
          nxt_dcy   = ctrl_data_in[dpgp_pkg::LIM_HI_LSB +: 4];
        end
        dpgp_pkg::ADDR_LIM2:
        begin
          nxt_lift = ctrl_data_in[3:0];
          nxt_lvl  = ctrl_data_in[dpgp_pkg::LIM_HI_LSB +: 3];
        end
        default: nxt_en = converter_path_enable_ff;
      endcase
    end
  end

  // Control registers.
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      converter_path_enable_ff <= 1'b0;
      soft_mute_request_ff     <= 1'b0;
      output_phase_invert_ff   <= 1'b0;
      zero_run_mute_control_ff <= 1'b0;
      deem_sel_ff              <= dpgp_pkg::DEEM_RST;
      playback_volume_code_ff  <= dpgp_pkg::VOL_RST;
      limiter_attack_rate_ff   <= dpgp_pkg::ATK_RST;
      limiter_decay_rate_ff    <= dpgp_pkg::DCY_RST;
      limiter_enable_ff        <= 1'b0;
      limiter_level_ff         <= dpgp_pkg::LVL_RST;
      limiter_gain_lift_ff     <= dpgp_pkg::LIFT_RST;
    end
    else
    begin
      converter_path_enable_ff <= nxt_en;
      soft_mute_request_ff     <= nxt_smreq;
      output_phase_invert_ff   <= nxt_inv;
      zero_run_mute_control_ff <= nxt_zero_run_mute_control;
      deem_sel_ff              <= nxt_deem;
      playback_volume_code_ff  <= nxt_vol;
      limiter_attack_rate_ff   <= nxt_atk;
      limiter_decay_rate_ff    <= nxt_dcy;
      limiter_enable_ff        <= nxt_limiter_enable;
      limiter_level_ff         <= nxt_lvl;
      limiter_gain_lift_ff     <= nxt_lift;
    end
  end

  assign att_v  = $signed({4'h0, 8'(dpgp_pkg::VOL_UNITY - playback_volume_code_ff)})
                + $signed({4'h0, smatt_ff});
  assign lift_e = (limiter_gain_lift_ff > dpgp_pkg::LIFT_MAX) ? dpgp_pkg::LIFT_MAX
                                                              : limiter_gain_lift_ff;
  assign att_l  = $signed({6'h0, latt_ff[19:dpgp_pkg::LIM_FRAC]})
                - $signed({7'h0, lift_e, 1'b0});
  assign lo     = gain(dm_ff, att_l);
  assign mag    = lo[23] ? 24'(-lo) : lo;
  assign lvl_i  = (limiter_level_ff > dpgp_pkg::LVL_MAX) ? dpgp_pkg::LVL_MAX
                                                         : limiter_level_ff;
  assign thr_up = dpgp_pkg::THR[lvl_i];
  assign thr_lo = dpgp_pkg::THR[lvl_i + 3'h1];
  assign atk_e  = (limiter_attack_rate_ff > dpgp_pkg::RATE_MAX) ? dpgp_pkg::RATE_MAX
                                                                : limiter_attack_rate_ff;
  assign dcy_e  = (limiter_decay_rate_ff > dpgp_pkg::RATE_MAX) ? dpgp_pkg::RATE_MAX
                                                               : limiter_decay_rate_ff;
  // Even the slowest code, capped at RATE_MAX, shifts the increment no lower than 2, so the
  // floor of one never takes effect and every code keeps its shifted increment.
  assign ainc   = ((dpgp_pkg::ATK_INC >> atk_e) == 20'h00000) ? 20'h00001
                                                               : dpgp_pkg::ATK_INC >> atk_e;
  assign dinc   = ((dpgp_pkg::DCY_INC >> dcy_e) == 20'h00000) ? 20'h00001
                                                               : dpgp_pkg::DCY_INC >> dcy_e;
  assign lsum   = {1'b0, latt_ff} + {1'b0, ainc};
  assign pn     = output_phase_invert_ff ? sat24(-48'(lo)) : lo;
  assign coef   = (deem_sel_ff == 2'h1) ? dpgp_pkg::DEEM_C32 :
                  (deem_sel_ff == 2'h2) ? dpgp_pkg::DEEM_C44 : dpgp_pkg::DEEM_C48;
  assign ddiff  = {dm_ff[23], dm_ff} - {g1_ff[23], g1_ff};
  assign dprod  = 48'(ddiff) * $signed({32'h0, coef});
  assign isum   = {prev_ff[23], prev_ff} + {pn[23], pn};

  // Only an idle path draws a sample; a disabled path drains and drops input.
  assign f_ready        = state_ff == dpgp_pkg::ST_IDLE;
  assign out_valid_out  = converter_path_enable_ff && (state_ff == dpgp_pkg::ST_OUT1 ||
                                                       state_ff == dpgp_pkg::ST_OUT2);
  assign out_data_out   = out_ff;
  assign zero_mute_out  = !zero_run_mute_control_ff && zcnt_ff == dpgp_pkg::ZERO_RUN;
  assign lim_active_out = latt_ff != '0;
  assign path_en_out    = converter_path_enable_ff;

  // Sample sequence: one stage per state, two output words per input sample.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_raw   = raw_ff;
    nxt_g1    = g1_ff;
    nxt_dm    = dm_ff;
    nxt_pol   = pol_ff;
    nxt_prev  = prev_ff;
    nxt_out   = out_ff;
    nxt_zcnt  = zcnt_ff;
    nxt_smatt = smatt_ff;
    nxt_latt  = latt_ff;
    case (state_ff)
      dpgp_pkg::ST_IDLE:
      begin
        if (f_valid && converter_path_enable_ff)
        begin
          nxt_raw   = f_data;
          nxt_state = dpgp_pkg::ST_VOL;
          if (f_data == 24'h000000)
          begin
            if (zcnt_ff != dpgp_pkg::ZERO_RUN) nxt_zcnt = zcnt_ff + 11'h001;
          end
          else
          begin
            nxt_zcnt = 11'h000;
          end
        end
      end
      dpgp_pkg::ST_VOL:
      begin
        if (playback_volume_code_ff == 8'h00 || smatt_ff == dpgp_pkg::SMUTE_FULL)
        begin
          nxt_g1 = 24'sh000000;
        end
        else
        begin
          nxt_g1 = gain(raw_ff, att_v);
        end
        nxt_state = dpgp_pkg::ST_DEEM;
      end
      dpgp_pkg::ST_DEEM:
      begin
        nxt_dm    = (deem_sel_ff == 2'h0) ? g1_ff
                                          : sat24(48'(g1_ff) + (dprod >>> 15));
        nxt_state = dpgp_pkg::ST_LIM;
      end
      dpgp_pkg::ST_LIM:
      begin
        nxt_pol   = pn;
        nxt_out   = isum[24:1];
        nxt_state = dpgp_pkg::ST_OUT1;
        if (!limiter_enable_ff)
        begin
          nxt_latt = 20'h00000;
        end
        else if (mag > thr_up)
        begin
          nxt_latt = (lsum > {1'b0, dpgp_pkg::LATT_CAP}) ? dpgp_pkg::LATT_CAP : lsum[19:0];
        end
        else if (mag < thr_lo)
        begin
          nxt_latt = (latt_ff > dinc) ? latt_ff - dinc : 20'h00000;
        end
      end
      dpgp_pkg::ST_OUT1:
      begin
        if (out_ready_in)
        begin
          nxt_out   = pol_ff;
          nxt_state = dpgp_pkg::ST_OUT2;
        end
      end
      dpgp_pkg::ST_OUT2:
      begin
        if (out_ready_in)
        begin
          nxt_prev  = pol_ff;
          nxt_state = dpgp_pkg::ST_IDLE;
          if (soft_mute_request_ff && smatt_ff != dpgp_pkg::SMUTE_FULL)
          begin
            nxt_smatt = smatt_ff + 8'h01;
          end
          else if (!soft_mute_request_ff && smatt_ff != 8'h00)
          begin
            nxt_smatt = smatt_ff - 8'h01;
          end
        end
      end
      default: nxt_state = dpgp_pkg::ST_IDLE;
    endcase
    if (!converter_path_enable_ff) nxt_state = dpgp_pkg::ST_IDLE;
  end

  // Datapath registers.
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state_ff <= dpgp_pkg::ST_IDLE;
      raw_ff   <= '0;
      g1_ff    <= '0;
      dm_ff    <= '0;
      pol_ff   <= '0;
      prev_ff  <= '0;
      out_ff   <= '0;
      zcnt_ff  <= '0;
      smatt_ff <= '0;
      latt_ff  <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      raw_ff   <= nxt_raw;
      g1_ff    <= nxt_g1;
      dm_ff    <= nxt_dm;
      pol_ff   <= nxt_pol;
      prev_ff  <= nxt_prev;
      out_ff   <= nxt_out;
      zcnt_ff  <= nxt_zcnt;
      smatt_ff <= nxt_smatt;
      latt_ff  <= nxt_latt;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_take;
    state_ff == dpgp_pkg::ST_IDLE && f_valid && converter_path_enable_ff;
  endsequence
  sequence s_done;
    state_ff == dpgp_pkg::ST_OUT2 && out_ready_in && converter_path_enable_ff;
  endsequence

  reset_values_a: assert property ($past(sys_rst_in) |->
    playback_volume_code_ff == 8'hFF && !converter_path_enable_ff && !limiter_enable_ff)
    else $error("control reset values wrong");
  zero_vol_a: assert property (state_ff == dpgp_pkg::ST_VOL &&
    playback_volume_code_ff == 8'h00 |=> g1_ff == 24'sh000000)
    else $error("zero volume code did not silence");
  path_off_a: assert property (!converter_path_enable_ff |-> !out_valid_out)
    else $error("output while path disabled");
  smute_down_a: assert property (s_done ##0 soft_mute_request_ff &&
    smatt_ff != 8'hFF |=> smatt_ff == $past(smatt_ff) + 8'h01)
    else $error("soft mute did not step down");
  zero_run_a: assert property (zcnt_ff == 11'h400 && !zero_run_mute_control_ff
    |-> zero_mute_out) else $error("zero run did not mute");
  nonzero_a: assert property (s_take ##0 f_data != 24'h000000
    |=> !zero_mute_out && zcnt_ff == 11'h000) else $error("nonzero did not unmute");
  zero_run_mute_control_off_a: assert property (zero_run_mute_control_ff |-> !zero_mute_out)
    else $error("zero-run mute while disabled");
  attack_a: assert property (state_ff == dpgp_pkg::ST_LIM && limiter_enable_ff &&
    mag > thr_up && latt_ff < 20'hC0000 |=> latt_ff > $past(latt_ff))
    else $error("limiter did not attack");
  lim_off_a: assert property (state_ff == dpgp_pkg::ST_LIM && !limiter_enable_ff
    |=> latt_ff == 20'h00000) else $error("limiter attenuation while off");
  two_words_a: assert property (s_take |-> ##4 out_valid_out
    || !converter_path_enable_ff) else $error("interpolated word late");
endmodule
`default_nettype wire

/* tb/dpgp_sample_src.sv */
// Sample source model standing in for the serial audio receiver.
`timescale 1ns/1ps
`default_nettype none
module dpgp_sample_src (
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [23:0] word_in,
  input  wire logic        smp_ready_in,
  output logic             smp_valid_out,
  output logic [23:0]      smp_data_out
);
  // The word is held until taken; afterwards the lines flip so stale data never looks valid.
  initial smp_valid_out = 1'b0;
  initial smp_data_out = 24'h000000;
  always @(posedge clk_in)
  begin
    if (go_in)
    begin
      smp_valid_out <= 1'b1;
      smp_data_out  <= word_in;
    end
    else if (smp_valid_out && smp_ready_in)
    begin
      smp_valid_out <= 1'b0;
      smp_data_out  <= ~smp_data_out;
    end
  end
endmodule
`default_nettype wire

/* tb/dpgp_gain_path_bench.sv */
// Self-checking bench for the playback gain path.
`timescale 1ns/1ps
`default_nettype none
module dpgp_gain_path_bench;
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, ctrl_wr_in = 1'b0, go = 1'b0;
  logic        out_ready_in = 1'b1, smp_valid, smp_ready, out_valid_out;
  logic        zero_mute_out, lim_active_out, path_en_out;
  logic [6:0]  ctrl_addr_in = 7'h00;
  logic [8:0]  ctrl_data_in = 9'h000;
  logic [23:0] word = 24'h000000, w1, w2, out_data_out, smp_data;
  int          err_total = 0, checks_done = 0;
  initial forever #4 clk_in = ~clk_in;
  dpgp_gain_path uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ctrl_wr_in(ctrl_wr_in),
    .ctrl_addr_in(ctrl_addr_in), .ctrl_data_in(ctrl_data_in), .smp_valid_in(smp_valid),
    .smp_ready_out(smp_ready), .playback_serial_in(smp_data), .out_valid_out(out_valid_out),
    .out_ready_in(out_ready_in), .out_data_out(out_data_out), .zero_mute_out(zero_mute_out),
    .lim_active_out(lim_active_out), .path_en_out(path_en_out));
  dpgp_sample_src src (.clk_in(clk_in), .go_in(go), .word_in(word),
    .smp_ready_in(smp_ready), .smp_valid_out(smp_valid), .smp_data_out(smp_data));
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Compares one value, counting and reporting a mismatch.
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Writes one control word with a single-cycle strobe.
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge clk_in);
    ctrl_wr_in <= 1'b1;
    ctrl_addr_in <= a;
    ctrl_data_in <= d;
    @(posedge clk_in);
    ctrl_wr_in <= 1'b0;
  endtask
  // Sends one sample and captures its word pair; the wait is bounded so a stall ends the run.
  task automatic play(input logic [23:0] s);
    int n;
    @(posedge clk_in);
    go <= 1'b1;
    word <= s;
    @(posedge clk_in);
    go <= 1'b0;
    for (n = 0; n < 40 && out_valid_out !== 1'b1; n++)
      @(negedge clk_in);
    if (n == 40)
    begin
      err_total++;
      stop_test();
    end
    w1 = out_data_out;
    @(negedge clk_in);
    w2 = out_data_out;
  endtask
  initial
  begin
    #700000;
    err_total++;
    stop_test();
  end
  initial
  begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(negedge clk_in);
    check(24'(path_en_out), 24'h000000);
    wr(dpgp_pkg::ADDR_PWR3, 9'h001);
    @(negedge clk_in);
    check(24'(path_en_out), 24'h000001);
    play(24'h001000);
    check(w1, 24'h000800);
    check(w2, 24'h001000);
    wr(dpgp_pkg::ADDR_VOL, 9'h0F3);
    play(24'h001000);
    play(24'h001000);
    check(w2, 24'h000800);
    wr(dpgp_pkg::ADDR_VOL, 9'h000);
    play(24'h001000);
    play(24'h001000);
    check(w2, 24'h000000);
    wr(dpgp_pkg::ADDR_VOL, 9'h0FF);
    wr(dpgp_pkg::ADDR_CONV, 9'h001);
    play(24'h001000);
    play(24'h001000);
    check(w2, 24'hFFF000);
    wr(dpgp_pkg::ADDR_CONV, 9'h000);
    repeat (1023) play(24'h000000);
    check(24'(zero_mute_out), 24'h000000);
    play(24'h000000);
    check(24'(zero_mute_out), 24'h000001);
    play(24'h001000);
    check(24'(zero_mute_out), 24'h000000);
    wr(dpgp_pkg::ADDR_CONV, 9'h004);
    repeat (1025) play(24'h000000);
    check(24'(zero_mute_out), 24'h000000);
    wr(dpgp_pkg::ADDR_CONV, 9'h040);
    play(24'h001000);
    check(24'(w2 == 24'h000000), 24'h000000);
    repeat (260) play(24'h001000);
    check(w2, 24'h000000);
    wr(dpgp_pkg::ADDR_CONV, 9'h000);
    repeat (260) play(24'h001000);
    check(w2, 24'h001000);
    wr(dpgp_pkg::ADDR_LIM1, 9'h100);
    repeat (20) play(24'h7FFFFF);
    check(24'(lim_active_out), 24'h000001);
    // Quiet samples sit below the lower threshold, so the attenuation decays away.
    repeat (200) play(24'h001000);
    check(24'(lim_active_out), 24'h000000);
    play(24'h7FFFFF);
    check(24'(lim_active_out), 24'h000001);
    // Disabling takes effect at the next sample boundary, so one sample must pass.
    wr(dpgp_pkg::ADDR_LIM1, 9'h000);
    play(24'h001000);
    check(24'(lim_active_out), 24'h000000);
    // A step from silence through the 32 kHz pole: 4096 less 4096 times pole over 2^15.
    play(24'h000000);
    wr(dpgp_pkg::ADDR_CONV, 9'h010);
    play(24'h001000);
    check(w2, 24'h000770);
    wr(dpgp_pkg::ADDR_CONV, 9'h000);
    // Twelve dB of lift with the limiter off is a factor of four.
    wr(dpgp_pkg::ADDR_LIM2, 9'h00C);
    play(24'h001000);
    check(w2, 24'h004000);
    stop_test();
  end
endmodule
`default_nettype wire
